// ==== rtl/conv_regs_pkg.sv ====
package conv_regs_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int TRIM_W = 13;
	localparam int TEMP_W = 8;
	localparam int PRESET_W = 3;
	localparam logic [6:0] TEMP_ADDR = 7'h06;
	localparam logic [6:0] MASK_ADDR = 7'h07;
	localparam logic [6:0] ITRIM_ADDR = 7'h08;
	localparam logic [6:0] QTRIM_ADDR = 7'h09;
	localparam logic [15:0] MASK_RESET = 16'hFFFF;
	localparam logic [15:0] MASK_USED = 16'hBFBC;
	localparam logic [12:0] TRIM_RESET = 13'h0000;
	localparam logic [2:0] PRESET_RESET = 3'h4;
	localparam logic [15:0] MID_SCALE = 16'h8000;
	localparam logic [7:0] TEMP_LOW_ZERO = 8'h00;
	localparam logic [2:0] TRIM_PAD = 3'h0;
	localparam int PRESET_LSB = 13;
	localparam int BLANK_BIT = 8;
	localparam int RW_BIT = 6;
	localparam logic [4:0] INSTR_LAST = 5'h07;
	localparam logic [4:0] FRAME_LAST = 5'h17;
	localparam logic [4:0] READ_SHIFT_FROM = 5'h09;
	localparam int MCLK_PERIOD_NS = 40;
	localparam int SCLK_READ_MIN_NS = 1000;
	localparam int SCLK_READ_MIN_CYC =
		(SCLK_READ_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
endpackage : conv_regs_pkg

// ==== rtl/regbus_if.sv ====
`timescale 1ns/1ps
interface regbus_if;
	logic        wr;
	logic        rd;
	logic [6:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport initiator (output wr, output rd, output addr, output wdata, input rdata);
	modport target (input wr, input rd, input addr, input wdata, output rdata);
endinterface : regbus_if

// ==== rtl/serial_port.sv ====
`timescale 1ns/1ps
module serial_port (
	input  wire logic  clk,      // System clock
	input  wire logic  rst_n,    // Synchronous reset, low
	input  wire logic  sclk,     // Serial clock level
	input  wire logic  sen_n,    // Frame enable, low
	input  wire logic  sdio_in,  // Data pin input
	output logic       sdio_out, // Data pin output
	output logic       sdio_oe,  // Data pin drive enable
	regbus_if.initiator bus      // Register access
);
	typedef enum logic [2:0] {IDLE, INSTR, WRITE, READ, HOLD} sp_state_t;
	sp_state_t   state;
	logic        sclk_d;
	logic [4:0]  cnt;
	logic [15:0] shift_in;
	logic [15:0] shift_out;
	logic [6:0]  addr_q;
	wire         rise = sclk & ~sclk_d;
	wire         fall = ~sclk & sclk_d;
	wire         instr_end = (state == INSTR) && rise && (cnt == conv_regs_pkg::INSTR_LAST);
	wire         is_read = shift_in[conv_regs_pkg::RW_BIT];
	wire [6:0]   addr_now = {shift_in[5:0], sdio_in};
	assign bus.addr  = (state == INSTR) ? addr_now : addr_q;
	assign bus.wdata = {shift_in[14:0], sdio_in};
	assign bus.rd    = instr_end && is_read && !sen_n;
	assign bus.wr    = (state == WRITE) && rise && !sen_n && (cnt == conv_regs_pkg::FRAME_LAST);
	assign sdio_out  = shift_out[15];
	assign sdio_oe   = (state == READ) && !sen_n;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= IDLE;
			sclk_d <= 1'b0;
			cnt <= 5'h00;
			shift_in <= 16'h0000;
			shift_out <= 16'h0000;
			addr_q <= 7'h00;
		end else begin
			sclk_d <= sclk;
			if (rise)
				shift_in <= {shift_in[14:0], sdio_in};
			if (sen_n) begin
				state <= IDLE;
				cnt <= 5'h00;
			end else begin
				if (rise)
					cnt <= cnt + 5'h01;
				case (state)
					IDLE: state <= INSTR;
					INSTR: if (instr_end) begin
						addr_q <= addr_now;
						state <= is_read ? READ : WRITE;
						if (is_read)
							shift_out <= bus.rdata;
					end
					WRITE: if (bus.wr)
						state <= HOLD;
					READ: if (fall && cnt >= conv_regs_pkg::READ_SHIFT_FROM)
						shift_out <= {shift_out[14:0], 1'b0};
					HOLD: state <= HOLD;
					default: state <= IDLE;
				endcase
			end
		end
	end
	frame_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		bus.wr |-> (cnt == conv_regs_pkg::FRAME_LAST) ##1 (state == HOLD && !bus.wr))
		else $error("write strobe not single at last frame bit");
	drive_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(sdio_oe) |-> $past(bus.rd) && sdio_out == $past(bus.rdata[15]))
		else $error("read word not presented after instruction");
	read_frame_c: cover property (@(posedge clk) disable iff (!rst_n) bus.rd);
endmodule : serial_port

// ==== rtl/offset_sync.sv ====
`timescale 1ns/1ps
module offset_sync #(
	parameter int TRIM_W = conv_regs_pkg::TRIM_W
) (
	input  wire logic              clk,      // System clock
	input  wire logic              rst_n,    // Synchronous reset, low
	input  wire logic              wr_i,     // I trim word written
	input  wire logic              auto_en,  // Auto-sync enabled
	input  wire logic [TRIM_W-1:0] i_shadow, // Programmed I trim
	input  wire logic [TRIM_W-1:0] q_shadow, // Programmed Q trim
	output logic      [TRIM_W-1:0] i_active, // Applied I trim
	output logic      [TRIM_W-1:0] q_active, // Applied Q trim
	output logic                   pend      // Sync due next edge
);
	// Pending flag lets the shadow settle before the joint transfer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend <= 1'b0;
			i_active <= conv_regs_pkg::TRIM_RESET;
			q_active <= conv_regs_pkg::TRIM_RESET;
		end else begin
			pend <= wr_i && auto_en;
			if (pend) begin
				i_active <= i_shadow;
				q_active <= q_shadow;
			end
		end
	end
	auto_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_i && auto_en |=> ##1 (i_active == $past(i_shadow) && q_active == $past(q_shadow)))
		else $error("auto-sync did not load both trims");
	no_auto_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_i && !auto_en && !pend |=> ##1 ($stable(i_active) && $stable(q_active)))
		else $error("trims changed without auto-sync");
	auto_sync_c: cover property (@(posedge clk) disable iff (!rst_n) pend);
endmodule : offset_sync

// ==== rtl/conv_cfg_regs.sv ====
`timescale 1ns/1ps
module conv_cfg_regs (
	input  wire logic        MCLK,          // System clock, 25 MHz
	input  wire logic        RST_N,         // Synchronous reset, low
	input  wire logic        SCLK,          // Serial port clock
	input  wire logic        SDENB_N,       // Serial frame enable, low
	input  wire logic        SDIO_IN,       // Serial data pin input
	output logic             SDIO_OUT,      // Serial data pin output
	output logic             SDIO_OE,       // Serial data pin drive enable
	input  wire logic [7:0]  TEMP_CODE,     // Temperature sensor result
	input  wire logic        AUTO_SYNC_EN,  // Auto-sync enable bit
	input  wire logic        FIFO_SYNC,     // FIFO sync event
	input  wire logic [15:0] ALARM_RAW,     // Unmasked alarm levels
	input  wire logic [15:0] I_SAMPLE,      // I channel data in
	input  wire logic [15:0] Q_SAMPLE,      // Q channel data in
	output logic      [15:0] ALARM_MASK,    // Alarm suppress word
	output logic             ALARM_PIN,     // Any unmasked alarm
	output logic      [12:0] I_TRIM,        // Applied I trim
	output logic      [12:0] Q_TRIM,        // Applied Q trim
	output logic      [2:0]  FIFO_RD_PTR,   // Read pointer load value
	output logic             FIFO_PTR_LOAD, // Read pointer load strobe
	output logic      [15:0] I_CONV_OUT,    // I converter channel data
	output logic      [15:0] Q_CONV_OUT     // Q converter channel data
);
	regbus_if bus ();

	logic [15:0] mask;
	logic [12:0] i_channel_trim;
	logic [12:0] q_channel_trim;
	logic [2:0]  preset;
	logic [7:0]  temp_hold;
	logic        sync_busy;
	logic        alarm_pin;
	logic        ptr_load;
	logic [2:0]  ptr_val;
	logic [15:0] i_out;
	logic [15:0] q_out;

	serial_port u_port (
		.clk      (MCLK),
		.rst_n    (RST_N),
		.sclk     (SCLK),
		.sen_n    (SDENB_N),
		.sdio_in  (SDIO_IN),
		.sdio_out (SDIO_OUT),
		.sdio_oe  (SDIO_OE),
		.bus      (bus.initiator)
	);

	// Address match shared by the read select and the write strobes
	function automatic logic reg_hit(input logic [6:0] addr, input logic [6:0] reg_addr);
		return addr == reg_addr;
	endfunction : reg_hit

	// Address decode
	wire sel_temp = reg_hit(bus.addr, conv_regs_pkg::TEMP_ADDR);
	wire sel_mask = reg_hit(bus.addr, conv_regs_pkg::MASK_ADDR);
	wire sel_i    = reg_hit(bus.addr, conv_regs_pkg::ITRIM_ADDR);
	wire sel_q    = reg_hit(bus.addr, conv_regs_pkg::QTRIM_ADDR);
	wire sel_none = !(sel_temp || sel_mask || sel_i || sel_q);
	wire hit_mask = bus.wr && sel_mask;
	wire hit_i    = bus.wr && sel_i;
	wire hit_q    = bus.wr && sel_q;

	// Unused mask bits stay at one whatever is written
	wire [15:0] next_mask = (bus.wdata & conv_regs_pkg::MASK_USED) |
		(conv_regs_pkg::MASK_RESET & ~conv_regs_pkg::MASK_USED);
	wire [12:0] next_i_trim = bus.wdata[12:0];
	wire [12:0] next_q_trim = bus.wdata[12:0];
	wire [2:0]  next_preset = bus.wdata[15:conv_regs_pkg::PRESET_LSB];

	// Read words
	wire [15:0] temp_word = {temp_hold, conv_regs_pkg::TEMP_LOW_ZERO};
	wire [15:0] i_word    = {conv_regs_pkg::TRIM_PAD, i_channel_trim};
	wire [15:0] q_word    = {preset, q_channel_trim};
	assign bus.rdata = sel_temp ? temp_word :
		sel_mask ? mask :
		sel_i    ? i_word :
		sel_q    ? q_word : 16'h0000;

	// Unmasked alarms
	wire [15:0] live_alarms = ALARM_RAW & ~mask;
	wire        blanking    = ALARM_RAW[conv_regs_pkg::BLANK_BIT];
	wire [15:0] next_i_out  = blanking ? conv_regs_pkg::MID_SCALE : I_SAMPLE;
	wire [15:0] next_q_out  = blanking ? conv_regs_pkg::MID_SCALE : Q_SAMPLE;

	// Sensor result has no reset; always follows the sensor
	always_ff @(posedge MCLK) begin
		temp_hold <= TEMP_CODE;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mask <= conv_regs_pkg::MASK_RESET;
		end else if (hit_mask) begin
			mask <= next_mask;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			i_channel_trim <= conv_regs_pkg::TRIM_RESET;
		end else if (hit_i) begin
			i_channel_trim <= next_i_trim;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			q_channel_trim <= conv_regs_pkg::TRIM_RESET;
			preset <= conv_regs_pkg::PRESET_RESET;
		end else if (hit_q) begin
			q_channel_trim <= next_q_trim;
			preset <= next_preset;
		end
	end

	offset_sync #(
		.TRIM_W (conv_regs_pkg::TRIM_W)
	) u_sync (
		.clk      (MCLK),
		.rst_n    (RST_N),
		.wr_i     (hit_i),
		.auto_en  (AUTO_SYNC_EN),
		.i_shadow (i_channel_trim),
		.q_shadow (q_channel_trim),
		.i_active (I_TRIM),
		.q_active (Q_TRIM),
		.pend     (sync_busy)
	);

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			ptr_load <= 1'b0;
			ptr_val <= conv_regs_pkg::PRESET_RESET;
		end else begin
			ptr_load <= FIFO_SYNC;
			if (FIFO_SYNC)
				ptr_val <= preset;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			alarm_pin <= 1'b0;
			i_out <= conv_regs_pkg::MID_SCALE;
			q_out <= conv_regs_pkg::MID_SCALE;
		end else begin
			alarm_pin <= |live_alarms;
			i_out <= next_i_out;
			q_out <= next_q_out;
		end
	end

	assign ALARM_MASK    = mask;
	assign ALARM_PIN     = alarm_pin;
	assign FIFO_RD_PTR   = ptr_val;
	assign FIFO_PTR_LOAD = ptr_load;
	assign I_CONV_OUT    = i_out;
	assign Q_CONV_OUT    = q_out;

	// Checks
	mask_reset_a: assert property (
		@(posedge MCLK)
		!RST_N |=> ALARM_MASK == conv_regs_pkg::MASK_RESET)
		else $error("mask not all ones after reset");

	mask_unused_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		(ALARM_MASK & ~conv_regs_pkg::MASK_USED) == ~conv_regs_pkg::MASK_USED)
		else $error("unused mask bit cleared");

	mask_write_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		hit_mask |=> (ALARM_MASK & conv_regs_pkg::MASK_USED) ==
			($past(bus.wdata) & conv_regs_pkg::MASK_USED))
		else $error("mask write not stored");

	alarm_gate_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		##1 ALARM_PIN == |($past(ALARM_RAW) & ~$past(ALARM_MASK)))
		else $error("alarm pin ignores mask");

	temp_read_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.rd && sel_temp |-> bus.rdata[7:0] == 8'h00 &&
			bus.rdata[15:8] == $past(TEMP_CODE))
		else $error("temperature word wrong");

	trim_reset_a: assert property (
		@(posedge MCLK)
		!RST_N |=> I_TRIM == 13'h0000 && Q_TRIM == 13'h0000 &&
			i_channel_trim == 13'h0000 && q_channel_trim == 13'h0000)
		else $error("trims not zero after reset");

	q_only_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		hit_q && !sync_busy |=> $stable(I_TRIM) && $stable(Q_TRIM))
		else $error("Q word write changed applied trims");

	i_reserved_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.rd && sel_i |-> bus.rdata[15:13] == 3'h0)
		else $error("reserved I word bits not zero");

	preset_load_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		FIFO_SYNC |=> FIFO_PTR_LOAD && FIFO_RD_PTR == $past(preset))
		else $error("read pointer preset not loaded");

	preset_reset_a: assert property (
		@(posedge MCLK)
		!RST_N |=> preset == 3'h4)
		else $error("preset not 100 after reset");

	blanking_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		blanking |=> I_CONV_OUT == 16'h8000 && Q_CONV_OUT == 16'h8000)
		else $error("outputs not mid-scale while blanked");

	pass_through_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!blanking |=> I_CONV_OUT == $past(I_SAMPLE) && Q_CONV_OUT == $past(Q_SAMPLE))
		else $error("samples not passed through");

	i_write_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		hit_i |=> i_channel_trim == $past(bus.wdata[12:0]))
		else $error("I trim word write not stored");

	q_write_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		hit_q |=> q_channel_trim == $past(bus.wdata[12:0]) &&
			preset == $past(bus.wdata[15:13]))
		else $error("Q trim word write not stored");

	idle_write_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.wr && !(sel_mask || sel_i || sel_q) |=> $stable(ALARM_MASK) &&
			$stable(i_channel_trim) && $stable(q_channel_trim) && $stable(preset))
		else $error("write to read-only or free address changed a register");

	unmapped_read_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.rd && sel_none |-> bus.rdata == 16'h0000)
		else $error("free address did not read zero");

	mask_read_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.rd && sel_mask |-> bus.rdata == ALARM_MASK)
		else $error("mask word read wrong");

	i_read_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.rd && sel_i |-> bus.rdata[12:0] == i_channel_trim)
		else $error("I trim word read wrong");

	q_read_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		bus.rd && sel_q |-> bus.rdata[12:0] == q_channel_trim &&
			bus.rdata[15:13] == preset)
		else $error("Q trim word read wrong");

	mask_hold_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!hit_mask |=> $stable(ALARM_MASK))
		else $error("mask changed without a write");

	shadow_hold_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!hit_i && !hit_q |=> $stable(i_channel_trim) && $stable(q_channel_trim) &&
			$stable(preset))
		else $error("trim word changed without a write");

	trim_change_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		$changed(I_TRIM) || $changed(Q_TRIM) |-> $past(sync_busy))
		else $error("applied trims changed without a sync");

	sync_pend_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		sync_busy |-> $past(hit_i) && $past(AUTO_SYNC_EN))
		else $error("sync raised without an I word write");

	no_sync_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!AUTO_SYNC_EN |=> !sync_busy)
		else $error("sync raised with auto-sync off");

	ptr_hold_a: assert property (
		@(posedge MCLK) disable iff (!RST_N)
		!FIFO_SYNC |=> !FIFO_PTR_LOAD && $stable(FIFO_RD_PTR))
		else $error("read pointer moved without FIFO sync");

	out_reset_a: assert property (
		@(posedge MCLK)
		!RST_N |=> !ALARM_PIN && I_CONV_OUT == conv_regs_pkg::MID_SCALE &&
			Q_CONV_OUT == conv_regs_pkg::MID_SCALE)
		else $error("outputs not idle after reset");

	ptr_reset_a: assert property (
		@(posedge MCLK)
		!RST_N |=> !FIFO_PTR_LOAD && FIFO_RD_PTR == conv_regs_pkg::PRESET_RESET)
		else $error("read pointer not preset after reset");

	blank_c: cover property (@(posedge MCLK) disable iff (!RST_N) blanking ##1 !blanking);
	trim_update_c: cover property (@(posedge MCLK) disable iff (!RST_N)
		hit_q ##[1:1000] hit_i ##2 I_TRIM != 13'h0000);
	preset_c: cover property (@(posedge MCLK) disable iff (!RST_N)
		FIFO_SYNC && preset != conv_regs_pkg::PRESET_RESET);
endmodule : conv_cfg_regs

// ==== dv/serial_host.sv ====
`timescale 1ns/1ps
module serial_host (
	input  wire logic mclk,    // System clock
	output logic      sclk,    // Serial clock, idle low
	output logic      sen_n,   // Frame enable, low
	output logic      sdio,    // Level on data pin
	input  wire logic dev_out, // Device data output
	input  wire logic dev_oe   // Device drive enable
);
	logic drv;
	logic hbit;
	// Released pin shows the inverse of the last host bit
	assign sdio = dev_oe ? dev_out : (drv ? hbit : ~hbit);
	initial begin
		sclk = 1'b0;
		sen_n = 1'b1;
		drv = 1'b0;
		hbit = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	// Half is the SCLK half period in MCLK cycles
	task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
		input int half, output logic [15:0] rdat);
		logic [23:0] sh;
		sh = {rd, addr, wd};
		rdat = 16'h0000;
		tick(1);
		sen_n = 1'b0;
		for (int i = 0; i < 24; i++) begin
			drv = !(rd && i >= 8);
			hbit = sh[23-i];
			tick(half);
			if (rd && i >= 8) begin
				rdat = {rdat[14:0], sdio};
			end
			sclk = 1'b1;
			tick(half);
			sclk = 1'b0;
		end
		tick(half);
		sen_n = 1'b1;
		drv = 1'b0;
		tick(3);
	endtask : frame
endmodule : serial_host

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic        mclk, rst_n, sclk, sen_n, sdio, sdio_out, sdio_oe;
	logic        auto_en, fifo_sync, alarm_pin, ptr_load;
	logic [7:0]  temp_code;
	logic [15:0] alarm_raw, i_smp, q_smp, mask_out, i_out, q_out, d, r;
	logic [12:0] i_trim, q_trim;
	logic [2:0]  rd_ptr;
	int          failures, checked, m_mask, m_i, m_q, m_pre, a_i, a_q;
	int          seed = 32'h22b2386f;

	conv_cfg_regs u_dut (.MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .SDENB_N(sen_n),
		.SDIO_IN(sdio), .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .TEMP_CODE(temp_code),
		.AUTO_SYNC_EN(auto_en), .FIFO_SYNC(fifo_sync), .ALARM_RAW(alarm_raw),
		.I_SAMPLE(i_smp), .Q_SAMPLE(q_smp), .ALARM_MASK(mask_out), .ALARM_PIN(alarm_pin),
		.I_TRIM(i_trim), .Q_TRIM(q_trim), .FIFO_RD_PTR(rd_ptr), .FIFO_PTR_LOAD(ptr_load),
		.I_CONV_OUT(i_out), .Q_CONV_OUT(q_out));
	serial_host u_host (.mclk(mclk), .sclk(sclk), .sen_n(sen_n), .sdio(sdio),
		.dev_out(sdio_out), .dev_oe(sdio_oe));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [15:0] rmod(input logic [6:0] a);
		case (a)
			7'h06: rmod = {temp_code, 8'h00};
			7'h07: rmod = 16'(m_mask);
			7'h08: rmod = {3'h0, 13'(m_i)};
			7'h09: rmod = {3'(m_pre), 13'(m_q)};
			default: rmod = 16'h0000;
		endcase
	endfunction : rmod
	task automatic wr(input logic [6:0] a, input logic [15:0] wd);
		u_host.frame(1'b0, a, wd, 2, r);
		if (a == 7'h07) m_mask = wd | ~conv_regs_pkg::MASK_USED;
		if (a == 7'h09) begin
			m_q = wd[12:0];
			m_pre = wd[15:13];
		end
		if (a == 7'h08) begin
			m_i = wd[12:0];
			if (auto_en) begin
				a_i = m_i;
				a_q = m_q;
			end
		end
	endtask : wr
	task automatic rchk(input logic [6:0] a);
		int half;
		half = (conv_regs_pkg::SCLK_READ_MIN_CYC + 1) / 2;
		if (a != conv_regs_pkg::TEMP_ADDR) half = 2;
		u_host.frame(1'b1, a, 16'h0000, half, r);
		chk($sformatf("reg %h", a), r, rmod(a));
	endtask : rchk
	task automatic trims();
		chk("i applied", 16'(i_trim), 16'(a_i));
		chk("q applied", 16'(q_trim), 16'(a_q));
	endtask : trims
	task automatic results();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	initial begin
		repeat (50000) @(posedge mclk);
		failures++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		auto_en = 1'b0;
		fifo_sync = 1'b0;
		alarm_raw = 16'h0000;
		temp_code = 8'h00;
		i_smp = 16'h0000;
		q_smp = 16'h0000;
		failures = 0;
		checked = 0;
		m_mask = 16'hFFFF;
		{m_i, m_q, a_i, a_q} = '0;
		m_pre = 4;
		tick(5);
		rst_n = 1'b1;
		chk("mask port", mask_out, 16'hFFFF);
		trims();
		chk("read ptr", 16'(rd_ptr), 16'h0004);
		for (int a = 6; a < 11; a++) rchk(7'(a));
		rchk(7'h7F);
		repeat (2) begin
			temp_code = 8'($random(seed));
			wr(7'h06, 16'($random(seed)));
			wr(7'h0A, 16'hFFFF);
			rchk(7'h06);
			rchk(7'h0A);
		end
		for (int b = 0; b < 16; b++) begin
			wr(7'h07, ~(16'h0001 << b));
			rchk(7'h07);
			chk("mask port", mask_out, 16'(m_mask));
			alarm_raw = 16'h0001 << b;
			tick(2);
			chk("alarm pin", 16'(alarm_pin), 16'(conv_regs_pkg::MASK_USED[b]));
			alarm_raw = 16'h0000;
		end
		for (int k = 0; k < 4; k++) begin
			auto_en = (k < 3);
			wr(7'h09, 16'($random(seed)));
			trims();
			wr(7'h08, 16'($random(seed)));
			trims();
			rchk(7'h08);
			rchk(7'h09);
			fifo_sync = 1'b1;
			tick(1);
			fifo_sync = 1'b0;
			chk("ptr load", 16'(ptr_load), 16'h0001);
			chk("read ptr", 16'(rd_ptr), 16'(m_pre));
			tick(1);
			chk("ptr load", 16'(ptr_load), 16'h0000);
		end
		for (int k = 0; k < 4; k++) begin
			d = 16'($random(seed));
			alarm_raw = {d[15:9], k[0], d[7:0]};
			i_smp = 16'($random(seed));
			q_smp = 16'($random(seed));
			tick(2);
			chk("i out", i_out, k[0] ? 16'h8000 : i_smp);
			chk("q out", q_out, k[0] ? 16'h8000 : q_smp);
		end
		results();
	end
endmodule : tb_top
